/* File: dils_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef DILS_DEFS_SVH
`define DILS_DEFS_SVH
`define DILS_CLK_HZ 125000000
`define DILS_FLASH_HZ 2
`define DILS_FLASH_HALF ((`DILS_CLK_HZ / `DILS_FLASH_HZ) / 2)
`define DILS_OFF_CTRL 12'h000
`define DILS_OFF_STAT 12'h004
`define DILS_OFF_IRQ_STAT 12'h008
`define DILS_OFF_IRQ_MASK 12'h00C
`define DILS_OFF_CH_DIAG 12'h010
`define DILS_OFF_CH_IRQ 12'h014
`define DILS_OFF_ID 12'h018
`define DILS_CTRL_GRP_EN 0
`define DILS_IRQ_DIAG 0
`define DILS_IRQ_GRP 1
`define DILS_IRQ_SYNC 2
`define DILS_IRQ_JIT 3
`define DILS_IRQ_DROP 4
`define DILS_CTRL_RESET 32'h0000_0000
`define DILS_MASK_RESET 32'h0000_0000
`endif

/* File: dils_pkg.sv */
// Types shared by the indicator and interrupt block
package dils_pkg;
  typedef struct packed {
    logic red;
    logic yellow;
  } dils_group_led_t;
  typedef struct packed {
    logic sync_loss;
    logic jitter_high;
    logic frame_drop;
  } dils_maint_t;
  typedef enum logic [1:0] {
    DILS_BUS_OK,
    DILS_BUS_NOLINK,
    DILS_BUS_NOCONN
  } dils_bus_t;
endpackage

/* File: dils_top.sv */
// Diagnostics/maintenance interrupts and front-panel indicator logic
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dils_defs.svh"

// Behaviour
// - Two interrupt classes: diagnostics and maintenance
// - Channel fault edges raise channel, group interrupts
// - Sync loss, jitter, frame drop: maintenance
// - Running cleanly: group, bus dark, power lit
// - Supply low or hardware fault: all dark
// - Bus fault flashes: linked, no connection
// - Bus fault steady while no link
// - Peripheral fault lights group red
// - Maintenance alarm without peripheral fault lights group yellow
// - One green link indicator per port
// - Link indicator follows port link state
// - Load supply indicator only on outputs
// - Channel indicator: green status, red fault
module dils_top
  import dils_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter bit HAS_OUTPUTS = 1'b1,
  parameter int FLASH_HALF = `DILS_FLASH_HALF,
  parameter logic [31:0] ID_VALUE = 32'h0000_A5A5 // Arbitrary value
)
(
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic supply_ok, // Electronics supply adequate
  input wire logic hw_fault, // Hardware fault
  input wire logic switched_load_supply, // Switched load supply present
  input wire logic [1:0] port_link, // Per-port link up
  input wire logic conn_valid, // Valid connection, data exchange
  input wire logic [2:0] maint_evt, // Sync, jitter, drop conditions
  input wire logic [CHANNELS-1:0] ch_fault, // Channel fault level
  input wire logic [CHANNELS-1:0] ch_status, // Channel status level
  output logic irq, // Level interrupt
  output logic diag_irq, // Diagnostics interrupt pending
  output logic maint_irq, // Maintenance interrupt pending
  output logic [1:0] group_fault_maint_led, // {red, yellow}
  output logic bus_fault_led, // Bus fault indicator
  output logic power_led, // Power indicator
  output logic port_one_link_led, // Port 1 link
  output logic port_two_link_led, // Port 2 link
  output logic load_supply_led, // Load supply indicator
  output logic [CHANNELS-1:0] ch_green_led, // Channel status
  output logic [CHANNELS-1:0] ch_red_led // Channel fault
);

  // Input synchronisers
  logic [1:0] link_s1, link_s2;
  logic [2:0] mnt_s1, mnt_s2, mnt_d;
  logic [CHANNELS-1:0] flt_s1, flt_s2, flt_d, sts_s1, sts_s2;
  logic [3:0] misc_s1, misc_s2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_s1 <= 2'h0;
      link_s2 <= 2'h0;
      mnt_s1 <= 3'h0;
      mnt_s2 <= 3'h0;
      mnt_d <= 3'h0;
      misc_s1 <= 4'h0;
      misc_s2 <= 4'h0;
    end
    else
    begin
      link_s1 <= port_link;
      link_s2 <= link_s1;
      mnt_s1 <= maint_evt;
      mnt_s2 <= mnt_s1;
      mnt_d <= mnt_s2;
      misc_s1 <= {supply_ok, hw_fault, switched_load_supply, conn_valid};
      misc_s2 <= misc_s1;
    end
  end

  wire sup_ok = misc_s2[3];
  wire hw_flt = misc_s2[2];
  wire load_ok = misc_s2[1];
  wire conn_ok = misc_s2[0];
  wire powered = sup_ok && !hw_flt;

  // Event detection
  wire [CHANNELS-1:0] ch_edge = flt_s2 ^ flt_d;
  wire [2:0] mnt_rise = mnt_s2 & ~mnt_d;
  wire any_ch_edge = |ch_edge;

  // Registers
  logic [31:0] ctrl;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  logic [CHANNELS-1:0] ch_irq;
  wire grp_en = ctrl[`DILS_CTRL_GRP_EN];

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == `DILS_OFF_CTRL;
  wire hit_stat = paddr == `DILS_OFF_STAT;
  wire hit_istat = paddr == `DILS_OFF_IRQ_STAT;
  wire hit_imask = paddr == `DILS_OFF_IRQ_MASK;
  wire hit_chd = paddr == `DILS_OFF_CH_DIAG;
  wire hit_chi = paddr == `DILS_OFF_CH_IRQ;
  wire hit_id = paddr == `DILS_OFF_ID;
  wire mapped = hit_ctrl || hit_stat || hit_istat || hit_imask || hit_chd ||
    hit_chi || hit_id;
  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
    {8{pstrb[0]}}};
  wire [31:0] wclr = (wr && hit_istat) ? (pwdata & wmask) : 32'h0;
  wire [31:0] wclr_ch = (wr && hit_chi) ? (pwdata & wmask) : 32'h0;

  // Sticky status, set wins over write-one-to-clear
  wire [4:0] ev;
  assign ev[`DILS_IRQ_DIAG] = any_ch_edge;
  assign ev[`DILS_IRQ_GRP] = any_ch_edge && grp_en;
  assign ev[`DILS_IRQ_SYNC] = mnt_rise[2];
  assign ev[`DILS_IRQ_JIT] = mnt_rise[1];
  assign ev[`DILS_IRQ_DROP] = mnt_rise[0];
  wire [4:0] next_irq_stat = (irq_stat & ~wclr[4:0]) | ev;
  wire [CHANNELS-1:0] next_ch_irq = (ch_irq & ~wclr_ch[CHANNELS-1:0]) |
    ch_edge;
  wire [4:0] pend = irq_stat & irq_mask;

  wire [31:0] stat_word = {22'h0, flt_s2 != '0, |mnt_s2, conn_ok, load_ok,
    hw_flt, sup_ok, link_s2, 2'h0};
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl :
    hit_stat ? stat_word :
    hit_istat ? {27'h0, irq_stat} :
    hit_imask ? {27'h0, irq_mask} :
    hit_chd ? 32'(flt_s2) :
    hit_chi ? 32'(ch_irq) :
    hit_id ? ID_VALUE : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `DILS_CTRL_RESET;
      irq_mask <= 5'h0;
      irq_stat <= 5'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      irq_stat <= next_irq_stat;
      if (wr && hit_ctrl)
        ctrl <= (ctrl & ~wmask) | (pwdata & wmask & 32'h0000_0001);
      if (wr && hit_imask)
        irq_mask <= (irq_mask & ~wmask[4:0]) | (pwdata[4:0] & wmask[4:0]);
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Per-channel synchronisers, event flags and indicators
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_ch
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          flt_s1[gi] <= 1'b0;
          flt_s2[gi] <= 1'b0;
          flt_d[gi] <= 1'b0;
          sts_s1[gi] <= 1'b0;
          sts_s2[gi] <= 1'b0;
          ch_irq[gi] <= 1'b0;
          ch_green_led[gi] <= 1'b0;
          ch_red_led[gi] <= 1'b0;
        end
        else
        begin
          flt_s1[gi] <= ch_fault[gi];
          flt_s2[gi] <= flt_s1[gi];
          flt_d[gi] <= flt_s2[gi];
          sts_s1[gi] <= ch_status[gi];
          sts_s2[gi] <= sts_s1[gi];
          ch_irq[gi] <= next_ch_irq[gi];
          ch_green_led[gi] <= powered && sts_s2[gi] && !flt_s2[gi];
          ch_red_led[gi] <= powered && flt_s2[gi];
        end
      end
    end
  endgenerate

  // Flash divider, fixed rate
  logic [$clog2(FLASH_HALF+1)-1:0] flash_cnt;
  logic flash;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_cnt <= '0;
      flash <= 1'b0;
    end
    else if (flash_cnt == ($bits(flash_cnt))'(FLASH_HALF - 1))
    begin
      flash_cnt <= '0;
      flash <= !flash;
    end
    else
      flash_cnt <= flash_cnt + 1'b1;
  end

  // Indicator decoding
  wire linked = |link_s2;
  dils_bus_t bus_state;
  assign bus_state = !linked ? DILS_BUS_NOLINK :
    !conn_ok ? DILS_BUS_NOCONN : DILS_BUS_OK;
  wire next_bf = !powered ? 1'b0 :
    (bus_state == DILS_BUS_NOLINK) ? 1'b1 :
    (bus_state == DILS_BUS_NOCONN) ? flash : 1'b0;
  wire periph_flt = |flt_s2;
  dils_group_led_t next_grp;
  assign next_grp.red = powered && periph_flt;
  assign next_grp.yellow = powered && !periph_flt && (|mnt_s2);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
      diag_irq <= 1'b0;
      maint_irq <= 1'b0;
      group_fault_maint_led <= 2'h0;
      bus_fault_led <= 1'b0;
      power_led <= 1'b0;
      port_one_link_led <= 1'b0;
      port_two_link_led <= 1'b0;
      load_supply_led <= 1'b0;
    end
    else
    begin
      irq <= |pend;
      diag_irq <= pend[`DILS_IRQ_DIAG] || pend[`DILS_IRQ_GRP];
      maint_irq <= |pend[4:2];
      group_fault_maint_led <= next_grp;
      bus_fault_led <= next_bf;
      power_led <= powered;
      port_one_link_led <= powered && link_s2[0];
      port_two_link_led <= powered && link_s2[1];
      load_supply_led <= HAS_OUTPUTS && powered && load_ok;
    end
  end

endmodule
`default_nettype wire

/* File: dils_top_asserts.sv */
// Checker for indicator and interrupt behaviour
`timescale 1ns/1ps
`default_nettype none
module dils_top_asserts
  import dils_pkg::*;
#(
  parameter int CHANNELS = 8
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic supply_ok, // Supply
  input wire logic hw_fault, // Hw fault
  input wire logic [1:0] port_link, // Links
  input wire logic conn_valid, // Connection
  input wire logic [2:0] maint_evt, // Maintenance conditions
  input wire logic [CHANNELS-1:0] ch_fault, // Faults
  input wire logic [CHANNELS-1:0] ch_status, // Status
  input wire logic irq, // Irq
  input wire logic diag_irq, // Diag irq
  input wire logic maint_irq, // Maint irq
  input wire logic [1:0] group_fault_maint_led, // Group
  input wire logic bus_fault_led, // Bus
  input wire logic power_led, // Power
  input wire logic port_one_link_led, // Port 1
  input wire logic port_two_link_led, // Port 2
  input wire logic [CHANNELS-1:0] ch_green_led, // Green
  input wire logic [CHANNELS-1:0] ch_red_led // Red
);
  logic [2:0] up;
  wire pw = supply_ok && !hw_fault;
  // Pipeline refilled after reset
  wire ok = (up == 3'h7);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up <= 3'h0;
    else if (!ok)
      up <= up + 3'h1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  dark_off_a: assert property (!$past(pw, 3) |->
    {group_fault_maint_led, bus_fault_led, power_led} == 4'h0) else $error("lit");
  power_lit_a: assert property (ok && $past(pw, 3) |-> power_led)
    else $error("power dark");
  bus_steady_a: assert property (ok && $past(pw && port_link == 2'h0, 3)
    |-> bus_fault_led && power_led) else $error("bus not lit");
  bus_dark_a: assert property (ok && $past(pw && |port_link && conn_valid, 3)
    |-> !bus_fault_led) else $error("bus lit");
  red_on_a: assert property (ok && $past(pw && |ch_fault, 3)
    |-> group_fault_maint_led == 2'h2) else $error("no red");
  yellow_on_a: assert property (ok && $past(pw && !(|ch_fault) &&
    |maint_evt, 3) |-> group_fault_maint_led == 2'h1) else $error("no yellow");
  link_led_a: assert property (ok && $past(pw, 3) |->
    {port_two_link_led, port_one_link_led} == $past(port_link, 3)) else $error("link");
  chan_led_a: assert property (ok && $past(pw, 3) |-> {ch_red_led, ch_green_led}
    == $past({ch_fault, ch_status & ~ch_fault}, 3)) else $error("channel");
  irq_sum_a: assert property (irq == (diag_irq || maint_irq))
    else $error("irq sum");
  cover property (irq);
  cover property (bus_fault_led && power_led);
  cover property (group_fault_maint_led == 2'h1);
endmodule
bind dils_top dils_top_asserts #(.CHANNELS(CHANNELS)) dils_top_asserts_inst (.*);
`default_nettype wire

/* File: dils_net_model.sv */
// Network-side model: link, connection and maintenance conditions
`timescale 1ns/1ps
`default_nettype none
module dils_net_model
  import dils_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic [1:0] link_req, // Cable per port
  input wire logic conn_req, // Controller connects
  input wire logic [2:0] maint_req, // Trouble to report
  output logic [1:0] port_link, // Link per port
  output logic conn_valid, // Connection accepted
  output logic [2:0] maint_evt // Sync, jitter, drop
);
  // No connection frame without a physical link
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {port_link, conn_valid, maint_evt} <= 6'h00;
    else
      {port_link, conn_valid, maint_evt} <= {link_req, conn_req && |link_req, maint_req};
endmodule
`default_nettype wire

/* File: tb_diag_interrupt_led_status.sv */
// Testbench for the indicator and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, o) begin compares++; if ((e) !== (o)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, o); end end
module tb_diag_interrupt_led_status;
  import dils_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic supply_ok = 1'b0, hw_fault = 1'b0, load = 1'b0, conn_req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, irq, diag_irq, maint_irq, bus_fault_led, power_led;
  logic port_one_link_led, port_two_link_led, load_supply_led, conn_valid, p, old;
  logic [1:0] grp, port_link, link_req = 2'h0;
  logic [2:0] maint_evt, maint_req = 3'h0;
  logic [7:0] ch_fault = 8'h00, ch_status = 8'h00, ch_green_led, ch_red_led;
  logic [6:0] msk;
  int fail_count = 0, compares = 0, seed = 47311, n;
  always #4 pclk = ~pclk;
  dils_top #(.FLASH_HALF(4)) dils_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_ok(supply_ok), .hw_fault(hw_fault),
    .switched_load_supply(load), .port_link(port_link), .conn_valid(conn_valid),
    .maint_evt(maint_evt), .ch_fault(ch_fault), .ch_status(ch_status), .irq(irq),
    .diag_irq(diag_irq), .maint_irq(maint_irq), .group_fault_maint_led(grp),
    .bus_fault_led(bus_fault_led), .power_led(power_led),
    .port_one_link_led(port_one_link_led), .port_two_link_led(port_two_link_led),
    .load_supply_led(load_supply_led), .ch_green_led(ch_green_led),
    .ch_red_led(ch_red_led));
  dils_net_model dils_net_model_inst (.pclk(pclk), .presetn(presetn),
    .link_req(link_req), .conn_req(conn_req), .maint_req(maint_req),
    .port_link(port_link), .conn_valid(conn_valid), .maint_evt(maint_evt));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task finish_test;
    $display("mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    finish_test;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h018, 32'h0);
    `CHK("id", 32'h0000A5A5, rd)
    apb(1'b0, 12'h01C, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    repeat (40)
    begin
      @(posedge pclk);
      {supply_ok, hw_fault, load, conn_req, link_req} <= 6'($random(seed));
      ch_fault <= 8'($random(seed));
      ch_status <= 8'($random(seed));
      wt(6);
      p = supply_ok && !hw_fault;
      msk = (p && |link_req && !conn_req) ? 7'h6F : 7'h7F;
      `CHK("leds", {p && |ch_fault, 1'b0, p && link_req == 2'h0, p, p && link_req[0], p && link_req[1], p && load} & msk, {grp, bus_fault_led, power_led, port_one_link_led, port_two_link_led, load_supply_led} & msk)
      `CHK("chan", p ? {ch_fault, ch_status & ~ch_fault} : 16'h0, {ch_red_led, ch_green_led})
    end
    @(posedge pclk);
    {supply_ok, hw_fault, link_req, conn_req, ch_fault} <= 13'h1400;
    wt(6);
    n = 0;
    repeat (16)
    begin
      old = bus_fault_led;
      wt(1);
      n += int'(old !== bus_fault_led);
    end
    `CHK("flash", 4, n)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("stat", 32'h18 | (32'(load) << 6), rd)
    link_req <= 2'h3;
    conn_req <= 1'b1;
    apb(1'b1, 12'h008, 32'h1F);
    apb(1'b1, 12'h014, 32'hFF);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00C, 32'h1F);
    ch_fault <= 8'h01;
    wt(6);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("diag in", 32'h3, rd)
    apb(1'b0, 12'h014, 32'h0);
    `CHK("ch irq", 32'h1, rd)
    `CHK("irq", 3'h6, {irq, diag_irq, maint_irq})
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h000, 32'h0);
    ch_fault <= 8'h00;
    wt(6);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("diag out", 32'h1, rd)
    apb(1'b1, 12'h008, 32'h1F);
    for (int i = 0; i < 3; i++)
    begin
      maint_req <= 3'(1 << i);
      wt(6);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("maint", 32'(1 << (4 - i)), rd)
      `CHK("yellow", 5'h0D, {grp, irq, diag_irq, maint_irq})
      apb(1'b1, 12'h00C, 32'h0);
      wt(2);
      `CHK("masked", 1'b0, irq)
      apb(1'b1, 12'h00C, 32'h1F);
      apb(1'b1, 12'h008, 32'h1F);
      maint_req <= 3'h0;
      wt(4);
    end
    finish_test;
  end
endmodule
`default_nettype wire
